// ===== inc/xelu_pkg.sv
`default_nettype none
package xelu_pkg;
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_READ  = 4'b0010,
    ST_MODIF = 4'b0100,
    ST_WRITE = 4'b1000
  } xelu_state_t;

  typedef struct packed {
    logic        we;
    logic [3:0]  idx;
    logic [31:0] data;
  } xelu_wb_t;

  typedef struct packed {
    logic        req;
    logic        wr;
    logic [31:0] addr;
    logic [7:0]  wdata;
  } xelu_bus_t;
endpackage : xelu_pkg
`default_nettype wire

// ===== inc/xelu_regs.svh
`ifndef XELU_REGS_SVH
`define XELU_REGS_SVH
// opcode patterns and masks
`define XELU_OP_XOR_RR_MASK   16'hF00F
`define XELU_OP_XOR_RR_CODE   16'h200A
`define XELU_OP_EXTRACT_CODE  16'h200D
`define XELU_OP_IMM_MASK      16'hFF00
`define XELU_OP_XOR_IMM_CODE  16'hCA00
`define XELU_OP_XOR_MEM_CODE  16'hCE00
// field positions
`define XELU_DST_REG_MSB      11
`define XELU_DST_REG_LSB      8
`define XELU_SRC_REG_MSB      7
`define XELU_SRC_REG_LSB      4
`define XELU_IMM_MSB          7
`define XELU_IMM_LSB          0
// timing counts and program counter step
`define XELU_CYC_SINGLE       1
`define XELU_CYC_MEM          3
`define XELU_PC_STEP          32'h0000_0002
`endif

// ===== rtl/xelu_alu.sv
`timescale 1ns/10ps
`default_nettype none
`include "xelu_regs.svh"
module xelu_alu (
  // operands
  input  wire logic [31:0] src_in,
  input  wire logic [31:0] dst_in,
  input  wire logic [7:0]  imm_in,
  // results
  output logic      [31:0] xor_rr_out,
  output logic      [31:0] xor_imm_out,
  output logic      [31:0] extract_out
);
  assign xor_rr_out  = dst_in ^ src_in;
  assign xor_imm_out = dst_in ^ {24'h00_0000, imm_in};
  assign extract_out = {src_in[15:0], dst_in[31:16]};
endmodule : xelu_alu
`default_nettype wire

// ===== rtl/xelu_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "xelu_regs.svh"
module xelu_top (
  // clock and reset
  input  wire logic        CLK_IN,
  input  wire logic        ARST_N_IN,
  // instruction issue
  input  wire logic        ISSUE_IN,
  input  wire logic [15:0] OPCODE_IN,
  input  wire logic [31:0] PC_IN,
  input  wire logic        TFLAG_IN,
  // register file read
  input  wire logic [31:0] SRC_DATA_IN,
  input  wire logic [31:0] DST_DATA_IN,
  input  wire logic [31:0] INDEX_REGISTER_ZERO_IN,
  input  wire logic [31:0] GLOBAL_BASE_REGISTER_IN,
  // data bus
  input  wire logic        BUS_ACK_IN,
  input  wire logic [7:0]  BUS_RDATA_IN,
  output logic             BUS_REQ_OUT,
  output logic             BUS_WR_OUT,
  output logic             BUS_LOCK_OUT,
  output logic      [31:0] BUS_ADDR_OUT,
  output logic      [7:0]  BUS_WDATA_OUT,
  // register file read select
  output logic      [3:0]  SRC_IDX_OUT,
  output logic      [3:0]  DST_IDX_OUT,
  // write back and completion
  output logic             WB_WE_OUT,
  output logic      [3:0]  WB_IDX_OUT,
  output logic      [31:0] WB_DATA_OUT,
  output logic             DONE_OUT,
  output logic             BUSY_OUT,
  output logic             ILLEGAL_OUT,
  output logic      [31:0] NEXT_PC_OUT,
  output logic             TFLAG_OUT
);
  ////////////////////////////////////////////////////////////////////////////
  // decode
  logic              is_xor_rr;
  logic              is_extract;
  logic              is_xor_imm;
  logic              is_xor_mem;
  logic [3:0]        destination_register;
  logic [3:0]        source_register;
  logic [7:0]        imm;
  xelu_pkg::xelu_state_t state;
  xelu_pkg::xelu_wb_t    next_wb;
  logic [31:0]       alu_dst;
  logic [31:0]       res_rr;
  logic [31:0]       res_imm;
  logic [31:0]       res_x;
  logic [7:0]        mem_imm;
  logic [7:0]        mem_byte;
  logic [31:0]       mem_addr;
  logic [31:0]       mem_pc;
  logic              mem_tflag;
  logic              can_issue;

  assign destination_register = OPCODE_IN[`XELU_DST_REG_MSB:`XELU_DST_REG_LSB];
  assign source_register      = OPCODE_IN[`XELU_SRC_REG_MSB:`XELU_SRC_REG_LSB];
  assign imm        = OPCODE_IN[`XELU_IMM_MSB:`XELU_IMM_LSB];
  assign can_issue  = ISSUE_IN && (state == xelu_pkg::ST_IDLE);
  assign is_xor_rr  = (OPCODE_IN & `XELU_OP_XOR_RR_MASK) == `XELU_OP_XOR_RR_CODE;
  assign is_extract = (OPCODE_IN & `XELU_OP_XOR_RR_MASK) == `XELU_OP_EXTRACT_CODE;
  assign is_xor_imm = (OPCODE_IN & `XELU_OP_IMM_MASK) == `XELU_OP_XOR_IMM_CODE;
  assign is_xor_mem = (OPCODE_IN & `XELU_OP_IMM_MASK) == `XELU_OP_XOR_MEM_CODE;

  assign SRC_IDX_OUT = source_register;
  assign DST_IDX_OUT = destination_register;
  assign BUSY_OUT    = (state != xelu_pkg::ST_IDLE);
  assign alu_dst     = is_xor_imm ? INDEX_REGISTER_ZERO_IN : DST_DATA_IN;

  xelu_alu u_alu (
    .src_in      (SRC_DATA_IN),
    .dst_in      (alu_dst),
    .imm_in      (imm),
    .xor_rr_out  (res_rr),
    .xor_imm_out (res_imm),
    .extract_out (res_x)
  );

  ////////////////////////////////////////////////////////////////////////////
  // single-cycle write back selection
  always_comb begin
    next_wb = '0;
    if (can_issue && is_xor_rr) begin
      next_wb = '{we: 1'b1, idx: destination_register, data: res_rr};
    end else if (can_issue && is_extract) begin
      next_wb = '{we: 1'b1, idx: destination_register, data: res_x};
    end else if (can_issue && is_xor_imm) begin
      next_wb = '{we: 1'b1, idx: 4'h0, data: res_imm};
    end
  end

  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      WB_WE_OUT   <= 1'b0;
      WB_IDX_OUT  <= 4'h0;
      WB_DATA_OUT <= 32'h0000_0000;
    end else begin
      WB_WE_OUT   <= next_wb.we;
      WB_IDX_OUT  <= next_wb.idx;
      WB_DATA_OUT <= next_wb.data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // byte memory read-modify-write sequencer
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      state     <= xelu_pkg::ST_IDLE;
      mem_imm   <= 8'h00;
      mem_byte  <= 8'h00;
      mem_addr  <= 32'h0000_0000;
      mem_pc    <= 32'h0000_0000;
      mem_tflag <= 1'b0;
    end else begin
      unique case (state)
        xelu_pkg::ST_IDLE: begin
          if (can_issue && is_xor_mem) begin
            state     <= xelu_pkg::ST_READ;
            mem_imm   <= imm;
            mem_addr  <= GLOBAL_BASE_REGISTER_IN + INDEX_REGISTER_ZERO_IN;
            mem_pc    <= PC_IN + `XELU_PC_STEP;
            mem_tflag <= TFLAG_IN;
          end
        end
        xelu_pkg::ST_READ: begin
          if (BUS_ACK_IN) begin
            mem_byte <= BUS_RDATA_IN;
            state    <= xelu_pkg::ST_MODIF;
          end
        end
        xelu_pkg::ST_MODIF: begin
          mem_byte <= mem_byte ^ mem_imm;
          state    <= xelu_pkg::ST_WRITE;
        end
        xelu_pkg::ST_WRITE: begin
          if (BUS_ACK_IN) begin
            state <= xelu_pkg::ST_IDLE;
          end
        end
        default: begin
          state <= xelu_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      BUS_REQ_OUT   <= 1'b0;
      BUS_WR_OUT    <= 1'b0;
      BUS_ADDR_OUT  <= 32'h0000_0000;
      BUS_WDATA_OUT <= 8'h00;
    end else begin
      if (state == xelu_pkg::ST_IDLE) begin
        BUS_ADDR_OUT <= GLOBAL_BASE_REGISTER_IN + INDEX_REGISTER_ZERO_IN;
      end else begin
        BUS_ADDR_OUT <= mem_addr;
      end
      // write byte loaded once, held steady through write wait states
      if (state == xelu_pkg::ST_MODIF) begin
        BUS_WDATA_OUT <= mem_byte ^ mem_imm;
      end
      if (state == xelu_pkg::ST_IDLE) begin
        BUS_REQ_OUT <= can_issue && is_xor_mem;
        BUS_WR_OUT  <= 1'b0;
      end else if (state == xelu_pkg::ST_READ) begin
        BUS_REQ_OUT <= !BUS_ACK_IN;
        BUS_WR_OUT  <= 1'b0;
      end else if (state == xelu_pkg::ST_MODIF) begin
        BUS_REQ_OUT <= 1'b1;
        BUS_WR_OUT  <= 1'b1;
      end else begin
        BUS_REQ_OUT <= !BUS_ACK_IN;
        BUS_WR_OUT  <= !BUS_ACK_IN;
      end
    end
  end

  // bus held locked through the read-modify-write
  assign BUS_LOCK_OUT = BUSY_OUT;

  ////////////////////////////////////////////////////////////////////////////
  // completion, program counter and test flag
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      DONE_OUT    <= 1'b0;
      ILLEGAL_OUT <= 1'b0;
      NEXT_PC_OUT <= 32'h0000_0000;
      TFLAG_OUT   <= 1'b0;
    end else begin
      ILLEGAL_OUT <= can_issue && !(is_xor_rr || is_extract || is_xor_imm || is_xor_mem);
      if (can_issue && (is_xor_rr || is_extract || is_xor_imm)) begin
        DONE_OUT    <= 1'b1;
        NEXT_PC_OUT <= PC_IN + `XELU_PC_STEP;
        TFLAG_OUT   <= TFLAG_IN;
      end else if (state == xelu_pkg::ST_WRITE && BUS_ACK_IN) begin
        DONE_OUT    <= 1'b1;
        NEXT_PC_OUT <= mem_pc;
        TFLAG_OUT   <= mem_tflag;
      end else begin
        DONE_OUT <= 1'b0;
      end
    end
  end
endmodule : xelu_top
`default_nettype wire

// ===== sim/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clk = 0, rst_n = 0, iss = 0, tf = 0, slow = 0;
  logic [15:0] op = 16'h0000;
  logic [31:0] pc = 32'h0000_1000, src = 0, dst = 0, rzero = 0, gbase = 0;
  wire logic req, wr, lock, ack, wb_we, done, busy, ill, tfo;
  wire logic [31:0] addr, wb_d, npc;
  wire logic [7:0] wd, rd;
  wire logic [3:0] si, di, wbi;
  int fail_count = 0, comparisons = 0, cyc = 0, n;
  always #2 clk = ~clk;
  xelu_top dut (.CLK_IN(clk), .ARST_N_IN(rst_n), .ISSUE_IN(iss), .OPCODE_IN(op),
    .PC_IN(pc), .TFLAG_IN(tf), .SRC_DATA_IN(src), .DST_DATA_IN(dst),
    .INDEX_REGISTER_ZERO_IN(rzero), .GLOBAL_BASE_REGISTER_IN(gbase), .BUS_ACK_IN(ack),
    .BUS_RDATA_IN(rd), .BUS_REQ_OUT(req),
    .BUS_WR_OUT(wr), .BUS_LOCK_OUT(lock), .BUS_ADDR_OUT(addr), .BUS_WDATA_OUT(wd),
    .SRC_IDX_OUT(si), .DST_IDX_OUT(di), .WB_WE_OUT(wb_we), .WB_IDX_OUT(wbi),
    .WB_DATA_OUT(wb_d), .DONE_OUT(done), .BUSY_OUT(busy), .ILLEGAL_OUT(ill),
    .NEXT_PC_OUT(npc), .TFLAG_OUT(tfo));
  xelu_mem_model bus (.clk_in(clk), .arst_n_in(rst_n), .req_in(req), .wr_in(wr),
    .slow_in(slow), .addr_in(addr), .wdata_in(wd), .ack_out(ack), .rdata_out(rd));
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic stop_test();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : stop_test
  task automatic issue(input logic [15:0] o);
    iss = 1;
    op = o;
    @(posedge clk);
    #1;
  endtask : issue
  task automatic t_reg();
    src = 32'hAAAA_AAAA;
    dst = 32'h5555_5555;
    tf = 1;
    issue(16'h210A);
    check(wb_d, 32'hFFFF_FFFF);
    check({wb_we, done, wbi}, 6'h31);
    check({tfo, npc}, {1'b1, pc + 32'h0000_0002});
    src = 32'h0123_4567;
    dst = 32'h89AB_CDEF;
    issue(16'h210D);
    iss = 0;
    check({di, si}, 8'h10);
    check(wb_d, 32'h4567_89AB);
    check({wb_we, done}, 2'b11);
    @(posedge clk);
    #1;
  endtask : t_reg
  task automatic t_imm();
    rzero = 32'hFFFF_FFFF;
    tf = 0;
    issue(16'hCAF0);
    iss = 0;
    check({wbi, wb_d}, {4'h0, 32'hFFFF_FF0F});
    check({tfo, done}, 2'b01);
    check(npc, pc + 32'h0000_0002);
    @(posedge clk);
    #1;
  endtask : t_imm
  task automatic t_mem(input logic s, input logic [7:0] imm, exp, input int exp_n);
    slow = s;
    gbase = 32'h0000_0100;
    rzero = 32'h0000_0005;
    pc = 32'h0000_2000;
    tf = 1;
    issue({8'hCE, imm});
    n = 1;
    check({busy, lock, req, wr, addr}, {4'b1110, 32'h0000_0105});
    op = 16'h210A;
    tf = 0;
    @(posedge clk);
    #1;
    n++;
    iss = 0;
    check(wb_we, 0);
    while (!done && n < 30) begin
      @(posedge clk);
      #1;
      n++;
    end
    check(n, exp_n);
    check({busy, bus.mem[5]}, {1'b0, exp});
    check({tfo, npc}, {1'b1, 32'h0000_2002});
  endtask : t_mem
  task automatic t_bad();
    issue(16'hFFFF);
    iss = 0;
    check({ill, wb_we, done}, 3'b100);
  endtask : t_bad
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      fail_count++;
      stop_test();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    #1;
    rst_n = 1;
    t_reg();
    t_imm();
    t_mem(0, 8'hA5, 8'h00, 4);
    t_mem(1, 8'h0F, 8'h0F, 8);
    t_bad();
    stop_test();
  end
endmodule : tb_top
`default_nettype wire

// ===== sim/xelu_checker.sv
`timescale 1ns/10ps
`default_nettype none
module xelu_checker (
  // clock and reset
  input  wire logic        CLK_IN,
  input  wire logic        ARST_N_IN,
  // instruction issue
  input  wire logic        ISSUE_IN,
  input  wire logic [15:0] OPCODE_IN,
  input  wire logic [31:0] PC_IN,
  input  wire logic        TFLAG_IN,
  // register file read
  input  wire logic [31:0] SRC_DATA_IN,
  input  wire logic [31:0] DST_DATA_IN,
  input  wire logic [31:0] INDEX_REGISTER_ZERO_IN,
  input  wire logic [31:0] GLOBAL_BASE_REGISTER_IN,
  // data bus
  input  wire logic        BUS_REQ_OUT,
  input  wire logic        BUS_WR_OUT,
  input  wire logic [31:0] BUS_ADDR_OUT,
  // results
  input  wire logic        BUSY_OUT,
  input  wire logic        WB_WE_OUT,
  input  wire logic [3:0]  WB_IDX_OUT,
  input  wire logic [31:0] WB_DATA_OUT,
  input  wire logic        DONE_OUT,
  input  wire logic [31:0] NEXT_PC_OUT,
  input  wire logic        TFLAG_OUT
);
  wire go = ISSUE_IN && !BUSY_OUT;
  wire rr = go && (OPCODE_IN & 16'hF00F) == 16'h200A;
  wire xt = go && (OPCODE_IN & 16'hF00F) == 16'h200D;
  wire im = go && OPCODE_IN[15:8] == 8'hCA;
  wire mm = go && OPCODE_IN[15:8] == 8'hCE;
  wire [31:0] rrx = DST_DATA_IN ^ SRC_DATA_IN;
  wire [31:0] mid = {SRC_DATA_IN[15:0], DST_DATA_IN[31:16]};
  wire [31:0] ix = INDEX_REGISTER_ZERO_IN ^ {24'h00_0000, OPCODE_IN[7:0]};
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!ARST_N_IN);
  a_xor_reg_write: assert property (rr |=> WB_WE_OUT && WB_DATA_OUT == $past(rrx))
    else $error("register xor result wrong");
  a_imm_zero_ext: assert property (im |=> WB_IDX_OUT == 4'h0 && WB_DATA_OUT == $past(ix))
    else $error("immediate xor result wrong");
  a_mem_read_addr: assert property (mm |=> BUS_REQ_OUT && !BUS_WR_OUT
    && BUS_ADDR_OUT == $past(GLOBAL_BASE_REGISTER_IN) + $past(INDEX_REGISTER_ZERO_IN))
    else $error("byte read wrong");
  a_mem_done_time: assert property (mm |=> (!DONE_OUT) [*3] ##[1:37] DONE_OUT)
    else $error("memory form timing wrong");
  a_extract_mid_word: assert property (xt |=> WB_DATA_OUT == $past(mid))
    else $error("extract result wrong");
  a_extract_one_cyc: assert property (xt |=> WB_WE_OUT && DONE_OUT)
    else $error("extract not done in one cycle");
  a_pc_flag_keep: assert property ((rr || xt || im) |=> TFLAG_OUT == $past(TFLAG_IN)
    && NEXT_PC_OUT == $past(PC_IN) + 32'h0000_0002) else $error("pc or flag wrong");
  c_back_to_back: cover property (rr ##1 xt);
  c_imm: cover property (im);
  c_mem: cover property (mm ##[4:40] DONE_OUT);
endmodule : xelu_checker
bind xelu_top xelu_checker u_chk (.CLK_IN, .ARST_N_IN, .ISSUE_IN, .BUSY_OUT, .WB_WE_OUT,
  .DONE_OUT, .BUS_REQ_OUT, .BUS_WR_OUT, .TFLAG_IN, .TFLAG_OUT, .OPCODE_IN, .WB_IDX_OUT,
  .PC_IN, .SRC_DATA_IN, .DST_DATA_IN, .INDEX_REGISTER_ZERO_IN, .GLOBAL_BASE_REGISTER_IN,
  .WB_DATA_OUT,
  .NEXT_PC_OUT, .BUS_ADDR_OUT);
`default_nettype wire

// ===== sim/xelu_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
module xelu_mem_model (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        arst_n_in,
  // request from the unit
  input  wire logic        req_in,
  input  wire logic        wr_in,
  input  wire logic [31:0] addr_in,
  input  wire logic [7:0]  wdata_in,
  // wait state mode
  input  wire logic        slow_in,
  // answer
  output logic             ack_out,
  output logic      [7:0]  rdata_out
);
  logic [7:0] mem [256];
  logic [1:0] wait_cnt;
  // slow mode holds each access two extra cycles
  assign ack_out = req_in && (!slow_in || wait_cnt == 2'd2);
  // read lane is junk outside the acked read
  assign rdata_out = (ack_out && !wr_in) ? mem[addr_in[7:0]] : ~mem[addr_in[7:0]];
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wait_cnt <= 2'd0;
      // preset while in reset: byte i holds 8'hA0 ^ i
      for (int i = 0; i < 256; i++) begin
        mem[i] <= 8'hA0 ^ 8'(i);
      end
    end else begin
      wait_cnt <= (req_in && !ack_out) ? wait_cnt + 2'd1 : 2'd0;
      if (ack_out && wr_in) begin
        mem[addr_in[7:0]] <= wdata_in;
      end
    end
  end
endmodule : xelu_mem_model
`default_nettype wire
